// ---- src/iee_map.svh ----
// Constants for the serial EEPROM instruction engine.
// Assumes inclusion by bare name from the package, the engine and the bench.
// Operation
// - Write: start, select with direction zero, two address bytes high first, all acked
// - Write cycle starts only on stop right after a data byte acknowledge
// - While writing internally the data driver is off and requests are ignored
// - After a write the counter points past the last modified byte
// - Write protect high: data bytes not acked, nothing written; low: acked
// - Page write stays inside one page, wrapping to the page start
// - Counter advances after every accepted data byte in a page write
// - Id page write: type 1011b, A10 zero, low seven bits pick the byte
// - Locked id page: data bytes of an id page write are not acked
// - Lock command: type 1011b, A10 one, data bit one set locks forever
// - Select during write cycle gets no ack; afterwards ack and carry on
// - Reads run whatever the write protect level
// - Each completed read byte advances the counter by one
// - Random read: write header without stop, repeated start, read select
// - Read select without address sends byte at counter, then advances it
// - One counter for memory and id page; id access loads page location
// - Sequential read continues while acked; counter wraps to zero
// - Lock status: id write header plus one byte, acked only if unlocked
// - Start mid-command resets command logic; truncated command never runs
// - In reads a high ninth bit from master ends transfer, standby
// - Id page holds 128 bytes; first three are identification codes
// - Select acked only for type 1010b memory or 1011b id page
// - Select acked only when chip bits match chip select pins
`ifndef IEE_MAP_SVH
`define IEE_MAP_SVH
`define IEE_TYPE_MEM      4'hA
`define IEE_TYPE_ID       4'hB
`define IEE_A10_BIT       2
`define IEE_LOCK_BIT      1
`define IEE_ACK_SLOT      4'h8
`define IEE_BIT_ZERO      4'h0
`define IEE_BIT_ONE       4'h1
`define IEE_PAGE_LAST     7'h7F
`define IEE_ADDR_RST      16'h0000
`define IEE_BYTE_ERASED   8'hFF
`define IEE_CORE_MHZ      40
`define IEE_WRITE_TIME_US 5000
`define IEE_MEM_DEPTH     65536
`define IEE_PAGE_DEPTH    128
`endif

// ---- src/iee_pkg.sv ----
// Types for the serial EEPROM instruction engine.
// Assumes nothing beyond the constants header.
`include "iee_map.svh"
package iee_pkg;
  typedef enum logic [2:0] {
    IEE_IDLE    = 3'h0,
    IEE_SELECT  = 3'h1,
    IEE_ADDR_HI = 3'h3,
    IEE_ADDR_LO = 3'h2,
    IEE_WDATA   = 3'h6,
    IEE_RDATA   = 3'h7
  } iee_state_type;
endpackage : iee_pkg

// ---- src/iee_engine.sv ----
// Serial EEPROM target: bus protocol, page buffer, arrays and write-cycle timer.
// Assumes link_clk_in runs freely and fast enough to oversample SCL and SDA;
// the SDA wire is resolved outside from sda_out and sda_oe_n_out.
`timescale 1ns/1ps
`default_nettype none
`include "iee_map.svh"
module iee_engine #(
  parameter int         WRITE_CYCLES = `IEE_WRITE_TIME_US * `IEE_CORE_MHZ,
  parameter logic [7:0] ID_CODE_0    = 8'h5A,  // Arbitrary value
  parameter logic [7:0] ID_CODE_1    = 8'h3C,  // Arbitrary value
  parameter logic [7:0] ID_CODE_2    = 8'h66   // Arbitrary value
) (
  input  wire logic       core_clk_in,
  input  wire logic       rst_in,
  input  wire logic       link_clk_in,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  input  wire logic       write_protect_input_in,
  input  wire logic [2:0] chip_select_pins_in,
  output logic            sda_out,
  output logic            sda_oe_n_out,
  output logic            write_busy_out,
  output logic            id_locked_out
);
  iee_pkg::iee_state_type state_reg;
  logic [1:0]  lrst_sync_reg;
  logic [2:0]  scl_sync_reg;
  logic [2:0]  sda_sync_reg;
  logic [1:0]  wp_sync_reg;
  logic [2:0]  cs_sync_0_reg;
  logic [2:0]  cs_sync_1_reg;
  logic [2:0]  done_sync_reg;
  logic [2:0]  req_sync_reg;
  logic [3:0]  bit_cnt_reg;
  logic        ack_phase_reg;
  logic        sda_oe_n_reg;
  logic [7:0]  shift_reg;
  logic [7:0]  tx_reg;
  logic [7:0]  addr_hi_reg;
  logic [15:0] addr_cnt_reg;
  logic [8:0]  page_base_reg;
  logic        sel_id_reg;
  logic        lock_cmd_reg;
  logic        lock_data_reg;
  logic        data_seen_reg;
  logic        inhibit_reg;
  logic [127:0] mask_reg;
  logic        busy_reg;
  logic        done_seen_reg;
  logic        commit_reg;
  logic [6:0]  commit_idx_reg;
  logic        id_locked_reg = 1'b0;  // Non-volatile: reset leaves the lock alone
  logic        req_tgl_reg;
  logic        done_tgl_reg;
  logic        core_busy_reg;
  logic [23:0] timer_reg;
  logic [7:0]  page_buf [0:`IEE_PAGE_DEPTH-1];
  logic [7:0]  id_page  [0:`IEE_PAGE_DEPTH-1];
  logic [7:0]  mem      [0:`IEE_MEM_DEPTH-1];

  logic link_rst;
  logic scl_rise;
  logic scl_fall;
  logic start_evt;
  logic stop_evt;
  logic live;
  logic ack_enter;
  logic ack_leave;
  logic sel_match;
  logic wdata_accept;
  logic stop_ok;
  logic wr_byte;
  logic [7:0] rd_byte;

  assign link_rst  = lrst_sync_reg[1];
  assign scl_rise  = scl_sync_reg[1] & ~scl_sync_reg[2];
  assign scl_fall  = ~scl_sync_reg[1] & scl_sync_reg[2];
  assign start_evt = scl_sync_reg[1] & scl_sync_reg[2] & sda_sync_reg[2] & ~sda_sync_reg[1];
  assign stop_evt  = scl_sync_reg[1] & scl_sync_reg[2] & ~sda_sync_reg[2] & sda_sync_reg[1];
  assign live      = ~busy_reg & ~start_evt & ~stop_evt & (state_reg != iee_pkg::IEE_IDLE);
  assign ack_enter = live & scl_fall & (bit_cnt_reg == `IEE_ACK_SLOT) & ~ack_phase_reg;
  assign ack_leave = live & scl_fall & ack_phase_reg;
  assign sel_match = ((shift_reg[7:4] == `IEE_TYPE_MEM) || (shift_reg[7:4] == `IEE_TYPE_ID))
                     && (shift_reg[3:1] == cs_sync_1_reg);
  assign wdata_accept = ~wp_sync_reg[1] & ~(sel_id_reg & id_locked_reg);
  // Stop comes after the tenth slot's SCL rise, so that rise is already counted
  assign stop_ok   = stop_evt & ~busy_reg & (state_reg == iee_pkg::IEE_WDATA)
                     & (bit_cnt_reg == `IEE_BIT_ONE) & ~ack_phase_reg
                     & data_seen_reg & ~inhibit_reg;
  assign wr_byte   = ack_enter & (state_reg == iee_pkg::IEE_WDATA) & wdata_accept
                     & ~lock_cmd_reg;
  // Only the low seven bits index the id page; master keeps reads inside it
  assign rd_byte   = sel_id_reg ? id_page[addr_cnt_reg[6:0]] : mem[addr_cnt_reg];
  assign sda_out        = 1'b0;
  assign sda_oe_n_out   = sda_oe_n_reg;
  assign write_busy_out = core_busy_reg;
  assign id_locked_out  = id_locked_reg;

  // Delivery state: erased array, codes in the first id bytes
  initial begin
    for (int i = 0; i < `IEE_MEM_DEPTH; i++) begin
      mem[i] = `IEE_BYTE_ERASED;
    end
    for (int i = 0; i < `IEE_PAGE_DEPTH; i++) begin
      id_page[i] = `IEE_BYTE_ERASED;
    end
    id_page[0] = ID_CODE_0;
    id_page[1] = ID_CODE_1;
    id_page[2] = ID_CODE_2;
  end

  // Pin and reset synchronisers on the link clock
  always_ff @(posedge link_clk_in) begin
    lrst_sync_reg <= {lrst_sync_reg[0], rst_in};
    scl_sync_reg  <= {scl_sync_reg[1:0], scl_in};
    sda_sync_reg  <= {sda_sync_reg[1:0], sda_in};
    wp_sync_reg   <= {wp_sync_reg[0], write_protect_input_in};
    cs_sync_0_reg <= chip_select_pins_in;
    cs_sync_1_reg <= cs_sync_0_reg;
    done_sync_reg <= {done_sync_reg[1:0], done_tgl_reg};
  end

  // Protocol engine
  always_ff @(posedge link_clk_in) begin
    if (link_rst) begin
      state_reg     <= iee_pkg::IEE_IDLE;
      bit_cnt_reg   <= `IEE_BIT_ZERO;
      ack_phase_reg <= 1'b0;
      sda_oe_n_reg  <= 1'b1;
      shift_reg     <= 8'h00;
      tx_reg        <= 8'h00;
      addr_hi_reg   <= 8'h00;
      addr_cnt_reg  <= `IEE_ADDR_RST;
      page_base_reg <= 9'h000;
      sel_id_reg    <= 1'b0;
      lock_cmd_reg  <= 1'b0;
      lock_data_reg <= 1'b0;
      data_seen_reg <= 1'b0;
      inhibit_reg   <= 1'b0;
      mask_reg      <= '0;
    end else if (busy_reg) begin
      state_reg     <= iee_pkg::IEE_IDLE;
      sda_oe_n_reg  <= 1'b1;
      ack_phase_reg <= 1'b0;
      bit_cnt_reg   <= `IEE_BIT_ZERO;
      if (done_seen_reg && !commit_reg && data_seen_reg && !lock_cmd_reg) begin
        data_seen_reg <= 1'b0;
      end
    end else if (start_evt) begin
      state_reg     <= iee_pkg::IEE_SELECT;
      bit_cnt_reg   <= `IEE_BIT_ZERO;
      ack_phase_reg <= 1'b0;
      sda_oe_n_reg  <= 1'b1;
    end else if (stop_evt) begin
      state_reg     <= iee_pkg::IEE_IDLE;
      sda_oe_n_reg  <= 1'b1;
      ack_phase_reg <= 1'b0;
    end else if (state_reg != iee_pkg::IEE_IDLE) begin
      if (scl_rise && bit_cnt_reg != `IEE_ACK_SLOT) begin
        shift_reg   <= {shift_reg[6:0], sda_sync_reg[1]};
        bit_cnt_reg <= 4'(bit_cnt_reg + 4'h1);
      end else if (scl_rise && state_reg == iee_pkg::IEE_RDATA && sda_sync_reg[1]) begin
        state_reg <= iee_pkg::IEE_IDLE;
      end
      if (ack_leave) begin
        ack_phase_reg <= 1'b0;
        bit_cnt_reg   <= `IEE_BIT_ZERO;
        sda_oe_n_reg  <= 1'b1;
        unique case (state_reg)
          iee_pkg::IEE_SELECT: begin
            if (shift_reg[0]) begin
              state_reg    <= iee_pkg::IEE_RDATA;
              tx_reg       <= rd_byte;
              sda_oe_n_reg <= rd_byte[7];
              addr_cnt_reg <= 16'(addr_cnt_reg + 16'h0001);
            end else begin
              state_reg <= iee_pkg::IEE_ADDR_HI;
            end
          end
          iee_pkg::IEE_ADDR_HI: state_reg <= iee_pkg::IEE_ADDR_LO;
          iee_pkg::IEE_ADDR_LO: state_reg <= iee_pkg::IEE_WDATA;
          iee_pkg::IEE_WDATA:   state_reg <= iee_pkg::IEE_WDATA;
          iee_pkg::IEE_RDATA: begin
            tx_reg       <= rd_byte;
            sda_oe_n_reg <= rd_byte[7];
            addr_cnt_reg <= 16'(addr_cnt_reg + 16'h0001);
          end
          default: state_reg <= iee_pkg::IEE_IDLE;
        endcase
      end else if (ack_enter) begin
        ack_phase_reg <= 1'b1;
        unique case (state_reg)
          iee_pkg::IEE_SELECT: begin
            if (sel_match) begin
              sda_oe_n_reg <= 1'b0;
              sel_id_reg   <= (shift_reg[7:4] == `IEE_TYPE_ID);
            end else begin
              state_reg <= iee_pkg::IEE_IDLE;
            end
          end
          iee_pkg::IEE_ADDR_HI: begin
            sda_oe_n_reg <= 1'b0;
            addr_hi_reg  <= shift_reg;
          end
          iee_pkg::IEE_ADDR_LO: begin
            sda_oe_n_reg  <= 1'b0;
            lock_cmd_reg  <= sel_id_reg & addr_hi_reg[`IEE_A10_BIT];
            data_seen_reg <= 1'b0;
            inhibit_reg   <= 1'b0;
            mask_reg      <= '0;
            if (sel_id_reg) begin
              addr_cnt_reg  <= {9'h000, shift_reg[6:0]};
              page_base_reg <= 9'h000;
            end else begin
              addr_cnt_reg  <= {addr_hi_reg, shift_reg};
              page_base_reg <= {addr_hi_reg, shift_reg[7]};
            end
          end
          iee_pkg::IEE_WDATA: begin
            sda_oe_n_reg  <= ~wdata_accept;
            data_seen_reg <= 1'b1;
            if (!wdata_accept) begin
              inhibit_reg <= 1'b1;
            end else if (lock_cmd_reg) begin
              lock_data_reg <= shift_reg[`IEE_LOCK_BIT];
            end else begin
              mask_reg[addr_cnt_reg[6:0]] <= 1'b1;
              addr_cnt_reg <= {addr_cnt_reg[15:7], 7'(addr_cnt_reg[6:0] + 7'h01)};
            end
          end
          iee_pkg::IEE_RDATA: sda_oe_n_reg <= 1'b1;
          default: state_reg <= iee_pkg::IEE_IDLE;
        endcase
      end else if (live && scl_fall && state_reg == iee_pkg::IEE_RDATA
                   && bit_cnt_reg != `IEE_BIT_ZERO) begin
        sda_oe_n_reg <= tx_reg[3'(4'h7 - bit_cnt_reg)];
      end
    end
  end

  // Page buffer collects accepted data bytes
  always_ff @(posedge link_clk_in) begin
    if (wr_byte) begin
      page_buf[addr_cnt_reg[6:0]] <= shift_reg;
    end
  end

  // Commit walks the page buffer while the timer runs
  always_ff @(posedge link_clk_in) begin
    if (link_rst) begin
      commit_reg     <= 1'b0;
      commit_idx_reg <= 7'h00;
    end else if (stop_ok) begin
      commit_reg     <= 1'b1;
      commit_idx_reg <= 7'h00;
    end else if (commit_reg) begin
      if (lock_cmd_reg) begin
        commit_reg <= 1'b0;
        if (lock_data_reg) begin
          id_locked_reg <= 1'b1;
        end
      end else begin
        commit_idx_reg <= 7'(commit_idx_reg + 7'h01);
        if (commit_idx_reg == `IEE_PAGE_LAST) begin
          commit_reg <= 1'b0;
        end
      end
    end
  end

  // Array writes; only bytes actually sent are modified
  always_ff @(posedge link_clk_in) begin
    if (commit_reg && !lock_cmd_reg && mask_reg[commit_idx_reg]) begin
      if (sel_id_reg) begin
        id_page[commit_idx_reg] <= page_buf[commit_idx_reg];
      end else begin
        mem[{page_base_reg, commit_idx_reg}] <= page_buf[commit_idx_reg];
      end
    end
  end

  // Busy: held until the core timer reports done and the commit has finished
  always_ff @(posedge link_clk_in) begin
    if (link_rst) begin
      busy_reg      <= 1'b0;
      done_seen_reg <= 1'b0;
      req_tgl_reg   <= 1'b0;
    end else if (stop_ok) begin
      busy_reg      <= 1'b1;
      done_seen_reg <= 1'b0;
      req_tgl_reg   <= ~req_tgl_reg;
    end else if (busy_reg) begin
      if (done_sync_reg[1] ^ done_sync_reg[2]) begin
        done_seen_reg <= 1'b1;
      end
      if (done_seen_reg && !commit_reg) begin
        busy_reg <= 1'b0;
      end
    end
  end

  // Write-cycle timer on the core clock
  always_ff @(posedge core_clk_in) begin
    req_sync_reg <= {req_sync_reg[1:0], req_tgl_reg};
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      core_busy_reg <= 1'b0;
      timer_reg     <= 24'h000000;
      done_tgl_reg  <= 1'b0;
    end else if (!core_busy_reg && (req_sync_reg[1] ^ req_sync_reg[2])) begin
      core_busy_reg <= 1'b1;
      timer_reg     <= 24'(WRITE_CYCLES);
    end else if (core_busy_reg) begin
      timer_reg <= 24'(timer_reg - 24'h000001);
      if (timer_reg == 24'h000001) begin
        core_busy_reg <= 1'b0;
        done_tgl_reg  <= ~done_tgl_reg;
      end
    end
  end

  busy_quiet_a: assert property (@(posedge link_clk_in) disable iff (link_rst)
    busy_reg |=> sda_oe_n_reg) else $error("driver active during write cycle");
  busy_ignore_a: assert property (@(posedge link_clk_in) disable iff (link_rst)
    busy_reg && start_evt |=> state_reg == iee_pkg::IEE_IDLE)
    else $error("start accepted while busy");
  wp_nack_a: assert property (@(posedge link_clk_in) disable iff (link_rst)
    ack_enter && state_reg == iee_pkg::IEE_WDATA && wp_sync_reg[1]
    |=> sda_oe_n_reg ##1 inhibit_reg)
    else $error("protected data byte acked");
  wp_ack_a: assert property (@(posedge link_clk_in) disable iff (link_rst)
    ack_enter && state_reg == iee_pkg::IEE_WDATA && !wp_sync_reg[1] && !sel_id_reg
    |=> !sda_oe_n_reg) else $error("data byte not acked");
  page_wrap_a: assert property (@(posedge link_clk_in) disable iff (link_rst)
    wr_byte |=> addr_cnt_reg[15:7] == $past(addr_cnt_reg[15:7])
    && addr_cnt_reg[6:0] == 7'($past(addr_cnt_reg[6:0]) + 7'h01))
    else $error("page counter wrong");
  stop_slot_a: assert property (@(posedge link_clk_in) disable iff (link_rst)
    stop_evt && !stop_ok |=> $stable(req_tgl_reg)) else $error("stray write cycle");
  lock_nack_a: assert property (@(posedge link_clk_in) disable iff (link_rst)
    ack_enter && state_reg == iee_pkg::IEE_WDATA && sel_id_reg && id_locked_reg
    |=> sda_oe_n_reg) else $error("locked page acked");
  bad_select_a: assert property (@(posedge link_clk_in) disable iff (link_rst)
    ack_enter && state_reg == iee_pkg::IEE_SELECT && !sel_match
    |=> state_reg == iee_pkg::IEE_IDLE && sda_oe_n_reg) else $error("foreign select acked");
  read_nack_a: assert property (@(posedge link_clk_in) disable iff (link_rst)
    live && scl_rise && state_reg == iee_pkg::IEE_RDATA && bit_cnt_reg == `IEE_ACK_SLOT
    && sda_sync_reg[1] |=> state_reg == iee_pkg::IEE_IDLE) else $error("read not ended");
  read_incr_a: assert property (@(posedge link_clk_in) disable iff (link_rst)
    ack_leave && (state_reg == iee_pkg::IEE_RDATA || state_reg == iee_pkg::IEE_SELECT
    && shift_reg[0]) |=> addr_cnt_reg == 16'($past(addr_cnt_reg) + 16'h0001))
    else $error("read counter not advanced");
  start_reset_a: assert property (@(posedge link_clk_in) disable iff (link_rst)
    start_evt && !busy_reg |=> state_reg == iee_pkg::IEE_SELECT && bit_cnt_reg == `IEE_BIT_ZERO)
    else $error("start did not reset");
  lock_set_a: assert property (@(posedge link_clk_in) disable iff (link_rst)
    $rose(id_locked_reg) |-> $past(commit_reg) && $past(lock_cmd_reg))
    else $error("lock set outside command");
  lock_keep_a: assert property (@(posedge link_clk_in)
    id_locked_reg |=> id_locked_reg) else $error("id page lock lost");
  id_load_a: assert property (@(posedge link_clk_in) disable iff (link_rst)
    ack_enter && state_reg == iee_pkg::IEE_ADDR_LO && sel_id_reg
    |=> addr_cnt_reg[15:7] == 9'h000) else $error("id counter high bits set");

  page_commit_c: cover property (@(posedge link_clk_in) disable iff (link_rst)
    stop_ok && !lock_cmd_reg ##1 busy_reg);
  read_end_c: cover property (@(posedge link_clk_in) disable iff (link_rst)
    state_reg == iee_pkg::IEE_RDATA ##1 state_reg == iee_pkg::IEE_IDLE);
  lock_c: cover property (@(posedge link_clk_in) disable iff (link_rst) $rose(id_locked_reg));
  poll_c: cover property (@(posedge link_clk_in) disable iff (link_rst) busy_reg && start_evt);
endmodule : iee_engine
`default_nettype wire

// ---- verification/iee_i2c_master.sv ----
// Bus master model: drives SCL and pulls SDA low or lets it go.
// Assumes the bench resolves SDA with a pull-up; the bench calls the tasks hierarchically.
`timescale 1ns/1ps
`default_nettype none
module iee_i2c_master #(
  parameter int Q_NS = 100
) (
  output logic      scl_out,
  output logic      sda_rel_out,
  input  wire logic sda_in
);
  initial begin
    scl_out     = 1'b1;
    sda_rel_out = 1'b1;
  end

  // Also a repeated start: SDA goes up while SCL is still low
  task automatic start_cond();
    sda_rel_out = 1'b1;
    #(Q_NS) scl_out = 1'b1;
    #(Q_NS) sda_rel_out = 1'b0;
    #(Q_NS) scl_out = 1'b0;
    #(Q_NS);
  endtask : start_cond

  task automatic stop_cond();
    sda_rel_out = 1'b0;
    #(Q_NS) scl_out = 1'b1;
    #(Q_NS) sda_rel_out = 1'b1;
    #(Q_NS);
  endtask : stop_cond

  // SDA changes only while SCL is low
  task automatic put_bit(input logic b);
    sda_rel_out = b;
    #(Q_NS) scl_out = 1'b1;
    #(2 * Q_NS) scl_out = 1'b0;
    #(Q_NS);
  endtask : put_bit

  task automatic get_bit(output logic b);
    sda_rel_out = 1'b1;
    #(Q_NS) scl_out = 1'b1;
    #(Q_NS) b = sda_in;
    #(Q_NS) scl_out = 1'b0;
    #(Q_NS);
  endtask : get_bit

  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic b;
    for (int i = 7; i >= 0; i--) begin
      put_bit(d[i]);
    end
    get_bit(b);
    ack = ~b;
  endtask : send_byte

  // Ninth slot: low asks for more, high ends the read
  task automatic recv_byte(input logic more, output logic [7:0] d);
    for (int i = 7; i >= 0; i--) begin
      get_bit(d[i]);
    end
    put_bit(~more);
  endtask : recv_byte
endmodule : iee_i2c_master
`default_nettype wire

// ---- verification/tb_i2c_eeprom_instruction_engine.sv ----
// Self-checking bench for the serial EEPROM instruction engine.
// Assumes the design sources and the bus master model are compiled first.
`timescale 1ns/1ps
`default_nettype none
`include "iee_map.svh"
module tb_i2c_eeprom_instruction_engine;
  localparam logic [7:0] ID0 = 8'h11;  // Arbitrary value
  localparam logic [7:0] ID1 = 8'h22;  // Arbitrary value
  localparam logic [7:0] ID2 = 8'h33;  // Arbitrary value
  typedef struct packed {
    logic [15:0] a;
    logic [7:0]  d;
    logic        wp;
  } iee_row_type;
  logic        core_clk     = 1'b0;
  logic        link_clk     = 1'b0;
  logic        rst          = 1'b1;
  logic        wp           = 1'b0;
  logic [2:0]  cs           = 3'h5;
  logic        scl;
  logic        sda_rel;
  logic        sda_o;
  logic        sda_oe_n;
  logic        busy;
  logic        locked;
  wire         sda_wire;
  int          err_count    = 0;
  int          total_checks = 0;
  iee_row_type rows [5]     = '{'{16'h0010, 8'hA5, 1'b0}, '{16'h0020, 8'h3C, 1'b1},
                                '{16'hFFFF, 8'h5A, 1'b0}, '{16'h0000, 8'hE1, 1'b0},
                                '{16'h0102, 8'h96, 1'b0}};

  always #12.5 core_clk = ~core_clk;
  initial begin
    #3.3;
    forever #7.5 link_clk = ~link_clk;
  end
  // Pull-up: the wire is low only when someone pulls it
  assign sda_wire = sda_rel & (sda_oe_n | sda_o);

  iee_engine #(.WRITE_CYCLES(400), .ID_CODE_0(ID0), .ID_CODE_1(ID1), .ID_CODE_2(ID2)) u_dut (
    .core_clk_in            (core_clk),
    .rst_in                 (rst),
    .link_clk_in            (link_clk),
    .scl_in                 (scl),
    .sda_in                 (sda_wire),
    .write_protect_input_in (wp),
    .chip_select_pins_in    (cs),
    .sda_out                (sda_o),
    .sda_oe_n_out           (sda_oe_n),
    .write_busy_out         (busy),
    .id_locked_out          (locked)
  );
  iee_i2c_master u_mst (
    .scl_out     (scl),
    .sda_rel_out (sda_rel),
    .sda_in      (sda_wire)
  );

  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : final_report

  task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
    total_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic sel(input logic [3:0] ty, input logic rw, output logic ack);
    u_mst.start_cond();
    u_mst.send_byte({ty, cs, rw}, ack);
  endtask : sel

  task automatic hdr(input logic [3:0] ty, input logic [15:0] a);
    logic k;
    sel(ty, 1'b0, k);
    chk(8'(k), 8'h01, "select ack");
    u_mst.send_byte(a[15:8], k);
    chk(8'(k), 8'h01, "addr hi ack");
    u_mst.send_byte(a[7:0], k);
    chk(8'(k), 8'h01, "addr lo ack");
  endtask : hdr

  // Busy device must refuse at least the first poll
  task automatic poll();
    logic k;
    int   n;
    k = 1'b0;
    n = 0;
    while (!k && n < 30) begin
      sel(`IEE_TYPE_MEM, 1'b0, k);
      n++;
    end
    u_mst.stop_cond();
    chk(8'(n > 1), 8'h01, "nacked polls");
    chk(8'(k), 8'h01, "ready ack");
  endtask : poll

  task automatic wr(input logic [3:0] ty, input logic [15:0] a, input logic [7:0] d[$],
                    input logic ack_exp);
    logic k;
    hdr(ty, a);
    foreach (d[i]) begin
      u_mst.send_byte(d[i], k);
      chk(8'(k), 8'(ack_exp), "data ack");
    end
    u_mst.stop_cond();
    #500;
    chk(8'(busy), 8'(ack_exp), "busy after stop");
    if (ack_exp) begin
      poll();
    end
  endtask : wr

  task automatic rd(input logic [3:0] ty, input logic [15:0] a, input logic [7:0] e[$],
                    input logic rnd);
    logic       k;
    logic [7:0] v;
    if (rnd) begin
      hdr(ty, a);
    end
    sel(ty, 1'b1, k);
    chk(8'(k), 8'h01, "read select ack");
    foreach (e[i]) begin
      u_mst.recv_byte(i < e.size() - 1, v);
      chk(v, e[i], "read data");
    end
    chk(8'(sda_oe_n), 8'h01, "released after nack");
    u_mst.stop_cond();
  endtask : rd

  task automatic status(input logic ack_exp);
    logic k;
    hdr(`IEE_TYPE_ID, 16'h0000);
    u_mst.send_byte(8'h00, k);
    chk(8'(k), 8'(ack_exp), "lock status");
    u_mst.start_cond();
    u_mst.stop_cond();
    #500;
    chk(8'(busy), 8'h00, "busy after status");
  endtask : status

  initial begin
    #2000000;
    err_count++;
    final_report();
  end

  initial begin
    logic k;
    repeat (8) @(posedge core_clk);
    #1;
    chk(8'(sda_oe_n), 8'h01, "oe_n in reset");
    chk(8'(busy), 8'h00, "busy in reset");
    chk(8'(locked), 8'h00, "locked in reset");
    repeat (2) @(posedge core_clk);
    #1 rst = 1'b0;
    repeat (10) @(posedge core_clk);
    foreach (rows[i]) begin
      @(posedge core_clk);
      #1 wp = rows[i].wp;
      wr(`IEE_TYPE_MEM, rows[i].a, '{rows[i].d}, ~rows[i].wp);
      rd(`IEE_TYPE_MEM, rows[i].a, '{rows[i].wp ? 8'hFF : rows[i].d}, 1'b1);
      @(posedge core_clk);
      #1 wp = 1'b0;
    end
    // Page roll-over: last two bytes land on the page start
    wr(`IEE_TYPE_MEM, 16'h017E, '{8'h61, 8'h62, 8'h63, 8'h64}, 1'b1);
    rd(`IEE_TYPE_MEM, 16'h0000, '{8'h96}, 1'b0);
    rd(`IEE_TYPE_MEM, 16'h017F, '{8'h62, 8'hFF}, 1'b1);
    rd(`IEE_TYPE_MEM, 16'h0100, '{8'h63, 8'h64, 8'h96}, 1'b1);
    rd(`IEE_TYPE_MEM, 16'hFFFF, '{8'h5A, 8'hE1}, 1'b1);
    for (int t = 0; t < 16; t++) begin
      sel(4'(t), 1'b0, k);
      u_mst.stop_cond();
      chk(8'(k), 8'(4'(t) == `IEE_TYPE_MEM || 4'(t) == `IEE_TYPE_ID), "type select");
    end
    for (int c = 0; c < 8; c++) begin
      u_mst.start_cond();
      u_mst.send_byte({`IEE_TYPE_MEM, 3'(c), 1'b0}, k);
      u_mst.stop_cond();
      chk(8'(k), 8'(3'(c) == cs), "chip select");
    end
    // Stop after the address, then start in the middle: neither may write
    hdr(`IEE_TYPE_MEM, 16'h0200);
    u_mst.stop_cond();
    hdr(`IEE_TYPE_MEM, 16'h0200);
    u_mst.send_byte(8'h99, k);
    u_mst.start_cond();
    u_mst.stop_cond();
    #500;
    chk(8'(busy), 8'h00, "busy after abort");
    rd(`IEE_TYPE_MEM, 16'h0200, '{8'hFF}, 1'b1);
    rd(`IEE_TYPE_ID, 16'hFF80, '{ID0, ID1, ID2}, 1'b1);
    wr(`IEE_TYPE_ID, 16'h7B85, '{8'hC7}, 1'b1);
    rd(`IEE_TYPE_ID, 16'h0005, '{8'hC7}, 1'b1);
    status(1'b1);
    wr(`IEE_TYPE_ID, 16'h0400, '{8'h02}, 1'b1);
    chk(8'(locked), 8'h01, "locked");
    status(1'b0);
    wr(`IEE_TYPE_ID, 16'h0005, '{8'h00}, 1'b0);
    rd(`IEE_TYPE_ID, 16'h0005, '{8'hC7}, 1'b1);
    @(posedge core_clk);
    #1 rst = 1'b1;
    repeat (10) @(posedge core_clk);
    #1 rst = 1'b0;
    repeat (10) @(posedge core_clk);
    #1 chk(8'(locked), 8'h01, "locked after reset");
    status(1'b0);
    final_report();
  end
endmodule : tb_i2c_eeprom_instruction_engine
`default_nettype wire
